// ---- rtl/spm_pkg.sv ----
// Shared constants, encodings and types for the switch power-mode controller.
package spm_pkg;
    // Clock and port count
    localparam int CLK_PERIOD_NS = 10;
    localparam int NUM_PORTS = 3;
    localparam int ADDR_W = 9;

    // Register indices (byte address is four times the index)
    localparam logic [6:0] IDX_POWER_MODE = 7'h0E;
    localparam logic [6:0] IDX_SLEEP_DELAY = 7'h0F;
    localparam logic [6:0] IDX_PORT_CTRL [NUM_PORTS] = '{7'h1D, 7'h2D, 7'h3D};
    localparam logic [6:0] IDX_EEE_CTRL = 7'h70;
    localparam logic [6:0] IDX_EEE_STATUS = 7'h72;

    // Field positions
    localparam int MODE_LSB = 3;
    localparam int PORT_PD_BIT = 3;

    // Power mode field encodings
    localparam logic [1:0] ENC_NORMAL = 2'h0;
    localparam logic [1:0] ENC_ENERGY = 2'h1;
    localparam logic [1:0] ENC_SOFT_PD = 2'h2;
    localparam logic [1:0] ENC_RSVD = 2'h3;

    // Reset values
    localparam logic [7:0] SLEEP_DELAY_RST = 8'h50;
    localparam logic NPORT_PD_RST = 1'b0;

    // Link pulse: 120 ns wide, one each second (width rounds up)
    localparam int PULSE_NS = 120;
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_PERIOD_NS = 1_000_000_000;
    localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;

    // One unit of the sleep-entry delay
    localparam int SLEEP_UNIT_NS = 1_000_000;
    localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_NS / CLK_PERIOD_NS;

    // MAC release delay after leaving low-power idle (least time, rounds up)
    localparam int WAKE_NS = 30_000;
    localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Operating modes
    typedef enum logic [1:0] {MODE_NORMAL, MODE_ENERGY, MODE_SOFT_PD} spm_mode_e;

    // Mode to register field encoding
    function automatic logic [1:0] spm_mode_enc(input spm_mode_e m);
        logic [1:0] e;
        e = ENC_NORMAL;
        if (m == MODE_ENERGY) e = ENC_ENERGY;
        if (m == MODE_SOFT_PD) e = ENC_SOFT_PD;
        return e;
    endfunction
endpackage

// ---- rtl/spm_port_if.sv ----
// Per-port bundle between the controller and its energy and idle engines.
interface spm_port_if;
    logic ed_mode;       // Energy-detect mode selected
    logic [7:0] delay;   // Sleep-entry delay in units
    logic sleep_tick;    // One pulse per delay unit
    logic sec_tick;      // One pulse per second
    logic energy;        // Cable energy seen
    logic low_power;     // Port in low-power state
    logic pulse;         // Link pulse toward the line
    logic eee_ok;        // Both ends advertised idle capability
    logic lpi_req;       // Idle request from software
    logic mac_tx_busy;   // MAC is sending a frame
    logic rx_lpi;        // Receive side shows assert-idle code
    logic rx_ifg;        // Receive side shows inter-frame code
    logic tx_lpi;        // Assert-idle code driven on transmit
    logic cs_hold;       // Carrier sense held toward MAC
    logic partner_idle;  // Partner signals idle
    logic clk_en;        // Port MAC clock may run

    modport ed (input ed_mode, delay, sleep_tick, sec_tick, energy, output low_power, pulse);
    modport lpi (input eee_ok, lpi_req, mac_tx_busy, rx_lpi, rx_ifg,
                 output tx_lpi, cs_hold, partner_idle, clk_en);
endinterface

// ---- rtl/spm_energy_port.sv ----
// Per-port energy-detect sleep and wake engine with link pulse generator.
module spm_energy_port (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    spm_port_if.ed port
);
    localparam int PW = $clog2(spm_pkg::PULSE_CYC + 1);
    localparam logic [PW-1:0] PULSE_LOAD = PW'(spm_pkg::PULSE_CYC);

    typedef enum logic {ED_AWAKE, ED_ASLEEP} spm_ed_state_e;
    spm_ed_state_e state, next_state;
    logic [7:0] idle_cnt;      // Delay units seen without energy
    logic [PW-1:0] pulse_cnt;  // Cycles left in the current pulse

    wire quiet = port.ed_mode & ~port.energy;
    wire expired = port.sleep_tick & (idle_cnt == port.delay);

    // Sleep once the quiet time passes the delay, wake on energy
    always_comb begin
        next_state = state;
        unique case (state)
            ED_AWAKE: if (quiet && expired) next_state = ED_ASLEEP;
            ED_ASLEEP: if (!quiet) next_state = ED_AWAKE;
        endcase
    end

    // State, quiet-time counter and pulse counter
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ED_AWAKE;
            idle_cnt <= 8'h00;
            pulse_cnt <= '0;
        end else begin
            state <= next_state;
            idle_cnt <= (!quiet || state == ED_ASLEEP) ? 8'h00 : idle_cnt + 8'(port.sleep_tick);
            if (state != ED_ASLEEP) pulse_cnt <= '0;
            else if (port.sec_tick) pulse_cnt <= PULSE_LOAD;
            else if (pulse_cnt != '0) pulse_cnt <= pulse_cnt - 1'b1;
        end
    end

    assign port.low_power = (state == ED_ASLEEP);
    assign port.pulse = (pulse_cnt != '0);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sleep_entry_a: assert property ($rose(port.low_power) |-> $past(quiet && port.sleep_tick))
        else $error("port slept without quiet delay expiry");
    energy_wake_a: assert property (port.low_power && !quiet |=> !port.low_power)
        else $error("port did not wake on energy");
    pulse_cause_a: assert property ($rose(port.pulse) |-> $past(port.sec_tick && port.low_power))
        else $error("link pulse without one-second tick");
    pulse_len_a: assert property ($rose(port.pulse) ##1 (port.low_power && !port.sec_tick)[*7] |-> port.pulse)
        else $error("link pulse ended too early");
endmodule

// ---- rtl/spm_lpi_port.sv ----
// Per-port low-power idle request, wake delay and partner idle detection.
module spm_lpi_port (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    spm_port_if.lpi port
);
    localparam int WW = $clog2(spm_pkg::WAKE_CYC + 1);
    localparam logic [WW-1:0] WAKE_LOAD = WW'(spm_pkg::WAKE_CYC);

    logic tx_lpi_q;          // Assert-idle code on transmit
    logic prev_ifg;          // Receive showed inter-frame code last cycle
    logic flag_q;            // Partner idle flag
    logic [WW-1:0] wake_cnt; // Cycles the MAC stays held after idle ends

    // Enter only between frames so no frame is cut; never without capability
    wire next_tx_lpi = port.eee_ok & port.lpi_req & (tx_lpi_q | ~port.mac_tx_busy);
    // Flag rises on inter-frame to assert-idle, holds while the code persists
    wire next_flag = port.rx_lpi & (flag_q | prev_ifg);

    // Transmit and receive directions run independently
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_lpi_q <= 1'b0;
            prev_ifg <= 1'b0;
            flag_q <= 1'b0;
            wake_cnt <= '0;
        end else begin
            tx_lpi_q <= next_tx_lpi;
            prev_ifg <= port.rx_ifg;
            flag_q <= next_flag;
            if (tx_lpi_q && !next_tx_lpi) wake_cnt <= WAKE_LOAD;
            else if (wake_cnt != '0) wake_cnt <= wake_cnt - 1'b1;
        end
    end

    assign port.tx_lpi = tx_lpi_q;
    assign port.cs_hold = tx_lpi_q | (wake_cnt != '0);
    assign port.partner_idle = flag_q;
    assign port.clk_en = ~(tx_lpi_q & flag_q);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    no_cap_idle_a: assert property (!port.eee_ok |=> !port.tx_lpi)
        else $error("idle asserted without shared capability");
    frame_safe_a: assert property ($rose(port.tx_lpi) |-> $past(!port.mac_tx_busy))
        else $error("idle entered during a frame");
    wake_hold_a: assert property ($fell(port.tx_lpi) |-> port.cs_hold[*8])
        else $error("MAC released too soon after idle");
    flag_rise_a: assert property (port.rx_ifg ##1 port.rx_lpi |=> port.partner_idle)
        else $error("partner idle flag not raised");
    flag_clear_a: assert property (!port.rx_lpi |=> !port.partner_idle)
        else $error("partner idle flag not cleared");
endmodule

// ---- rtl/spm_power_ctrl.sv ----
// Switch power-mode controller: mode register file, dividers and per-port engines.
//
// Decided for this implementation: the Avalon-MM slave port.
module spm_power_ctrl #(
    parameter int SEC_CYC = spm_pkg::PULSE_PERIOD_CYC,
    parameter int SLEEP_UNIT_CYC = spm_pkg::SLEEP_UNIT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [spm_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [spm_pkg::NUM_PORTS-1:0] energy_i,
    input wire logic [spm_pkg::NUM_PORTS-1:0] phy_basic_control_pd_i,
    input wire logic [spm_pkg::NUM_PORTS-1:0] eee_local_adv_i,
    input wire logic [spm_pkg::NUM_PORTS-1:0] eee_partner_adv_i,
    input wire logic [spm_pkg::NUM_PORTS-1:0] mac_tx_busy_i,
    input wire logic [spm_pkg::NUM_PORTS-1:0] mii_rx_lpi_i,
    input wire logic [spm_pkg::NUM_PORTS-1:0] mii_rx_ifg_i,
    output logic [spm_pkg::NUM_PORTS-1:0] phy_enable_o,
    output logic [spm_pkg::NUM_PORTS-1:0] link_pulse_o,
    output logic [spm_pkg::NUM_PORTS-1:0] mii_tx_lpi_o,
    output logic [spm_pkg::NUM_PORTS-1:0] mac_crs_hold_o,
    output logic [spm_pkg::NUM_PORTS-1:0] partner_idle_flag_o,
    output logic [spm_pkg::NUM_PORTS-1:0] mac_clk_en_o,
    output logic pll_clk_en_o,
    output logic host_if_en_o,
    output logic soft_reset_o
);
    localparam int NP = spm_pkg::NUM_PORTS;
    localparam int SW = $clog2(SEC_CYC);
    localparam int UW = $clog2(SLEEP_UNIT_CYC);
    localparam logic [SW-1:0] SEC_LAST = SW'(SEC_CYC - 1);
    localparam logic [UW-1:0] UNIT_LAST = UW'(SLEEP_UNIT_CYC - 1);

    // ---------------- Bus handshake ----------------
    logic ack_q;  // Set for the cycle in which waitrequest is low
    wire req = avs_read_i | avs_write_i;
    // A request completes at the edge where waitrequest is seen low
    wire take = req & ack_q;
    wire [6:0] idx = avs_address_i[8:2];
    // Writable registers are 8 bits wide and live in byte lane 0
    wire wr_lane0 = avs_write_i & take & avs_byteenable_i[0];

    // One wait state on every access keeps the read path registered
    assign avs_waitrequest_o = req & ~ack_q;

    // Wait-state flop
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ---------------- Register state ----------------
    spm_pkg::spm_mode_e mode_q, next_mode;  // Current power mode
    logic [7:0] sleep_delay;                // Sleep-entry delay in units
    logic [NP-1:0] port_pd;                 // Per-port power-down bits
    logic [NP-1:0] lpi_req_q;               // Software idle request per port
    wire [NP-1:0] low_power;                // Ports in low-power state
    wire [NP-1:0] tx_lpi;                   // Ports sending assert-idle code
    wire [NP-1:0] partner_idle;             // Partners signalling idle
    wire [NP-1:0] eee_ok = eee_local_adv_i & eee_partner_adv_i;

    // Address decode
    wire hit_mode = (idx == spm_pkg::IDX_POWER_MODE);
    wire hit_delay = (idx == spm_pkg::IDX_SLEEP_DELAY);
    wire hit_eee_ctrl = (idx == spm_pkg::IDX_EEE_CTRL);
    wire hit_eee_stat = (idx == spm_pkg::IDX_EEE_STATUS);
    wire [NP-1:0] hit_port;

    // Any access while powered down wakes the part; its write is discarded
    wire wake_access = take & (mode_q == spm_pkg::MODE_SOFT_PD);
    wire wr_ok = wr_lane0 & ~wake_access;
    wire [1:0] wr_enc = avs_writedata_i[spm_pkg::MODE_LSB +: 2];
    wire is_soft = (mode_q == spm_pkg::MODE_SOFT_PD);
    wire is_energy = (mode_q == spm_pkg::MODE_ENERGY);

    // Mode field decode; the reserved code leaves the mode alone
    always_comb begin
        next_mode = mode_q;
        if (wake_access) begin
            next_mode = spm_pkg::MODE_NORMAL;
        end else if (wr_ok && hit_mode) begin
            unique case (wr_enc)
                spm_pkg::ENC_NORMAL: next_mode = spm_pkg::MODE_NORMAL;
                spm_pkg::ENC_ENERGY: next_mode = spm_pkg::MODE_ENERGY;
                spm_pkg::ENC_SOFT_PD: next_mode = spm_pkg::MODE_SOFT_PD;
                spm_pkg::ENC_RSVD: next_mode = mode_q;
            endcase
        end
    end

    // Mode register; hardware reset lands in normal operation
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= spm_pkg::MODE_NORMAL;
        end else begin
            mode_q <= next_mode;
        end
    end

    // Global registers; a wake access restores every default
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_delay <= spm_pkg::SLEEP_DELAY_RST;
            lpi_req_q <= '0;
            soft_reset_o <= 1'b0;
        end else begin
            soft_reset_o <= wake_access;
            if (wake_access) begin
                sleep_delay <= spm_pkg::SLEEP_DELAY_RST;
                lpi_req_q <= '0;
            end else begin
                if (wr_ok && hit_delay) sleep_delay <= avs_writedata_i[7:0];
                if (wr_ok && hit_eee_ctrl) lpi_req_q <= avs_writedata_i[NP-1:0];
            end
        end
    end

    // ---------------- Read path ----------------
    logic [31:0] next_rdata;  // Word selected by the decoded index

    // Read mux; unmapped indices return zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_mode) next_rdata = {27'h0, spm_pkg::spm_mode_enc(mode_q), 3'h0};
        if (hit_delay) next_rdata = {24'h0, sleep_delay};
        if (hit_eee_ctrl) next_rdata = {25'h0, eee_ok, 1'b0, lpi_req_q};
        if (hit_eee_stat) next_rdata = {21'h0, tx_lpi, 1'b0, low_power, 1'b0, partner_idle};
        for (int i = 0; i < NP; i++) begin
            if (hit_port[i]) next_rdata = {28'h0, port_pd[i], 3'h0};
        end
    end

    // Read data is captured on the first edge so it stands at the taking edge
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            avs_readdata_o <= next_rdata;
        end
    end

    // ---------------- Rate dividers ----------------
    logic [SW-1:0] sec_cnt;   // Counts one second
    logic [UW-1:0] unit_cnt;  // Counts one sleep-delay unit
    wire sec_tick = (sec_cnt == SEC_LAST);
    wire unit_tick = (unit_cnt == UNIT_LAST);

    // Free-running dividers; the quiet timer therefore has one unit of slack
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sec_cnt <= '0;
            unit_cnt <= '0;
        end else begin
            sec_cnt <= sec_tick ? '0 : sec_cnt + 1'b1;
            unit_cnt <= unit_tick ? '0 : unit_cnt + 1'b1;
        end
    end

    // ---------------- Global clock enables ----------------
    // The device sleeps as a whole only when every port has gone quiet
    wire all_asleep = is_energy & (&low_power);
    assign pll_clk_en_o = ~is_soft & ~all_asleep;
    // Marks the host side as idle; this slave stays awake so an access still wakes it
    assign host_if_en_o = ~is_soft & ~all_asleep;

    // ---------------- Per-port engines ----------------
    for (genvar p = 0; p < NP; p++) begin : g_port
        spm_port_if pif ();

        assign hit_port[p] = (idx == spm_pkg::IDX_PORT_CTRL[p]);

        // Port power-down bit, cleared by a wake access
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                port_pd[p] <= spm_pkg::NPORT_PD_RST;
            end else if (wake_access) begin
                port_pd[p] <= spm_pkg::NPORT_PD_RST;
            end else if (wr_ok && hit_port[p]) begin
                port_pd[p] <= avs_writedata_i[spm_pkg::PORT_PD_BIT];
            end
        end

        // Energy engine inputs
        assign pif.ed_mode = is_energy;
        assign pif.delay = sleep_delay;
        assign pif.sleep_tick = unit_tick;
        assign pif.sec_tick = sec_tick;
        assign pif.energy = energy_i[p];

        // Idle engine inputs; a sleeping port or soft power-down asks for nothing
        assign pif.eee_ok = eee_ok[p];
        assign pif.lpi_req = lpi_req_q[p] & ~low_power[p] & ~is_soft;
        assign pif.mac_tx_busy = mac_tx_busy_i[p];
        assign pif.rx_lpi = mii_rx_lpi_i[p];
        assign pif.rx_ifg = mii_rx_ifg_i[p];

        spm_energy_port u_energy (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .port(pif.ed)
        );

        spm_lpi_port u_lpi (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .port(pif.lpi)
        );

        assign low_power[p] = pif.low_power;
        assign tx_lpi[p] = pif.tx_lpi;
        assign partner_idle[p] = pif.partner_idle;

        // PHY stays on only in an awake, enabled port
        assign phy_enable_o[p] = ~port_pd[p] & ~phy_basic_control_pd_i[p] & ~is_soft
                               & ~low_power[p];
        assign link_pulse_o[p] = pif.pulse;
        assign mii_tx_lpi_o[p] = pif.tx_lpi;
        assign mac_crs_hold_o[p] = pif.cs_hold;
        assign partner_idle_flag_o[p] = pif.partner_idle;
        // MAC clock off while powered down, asleep or idle in both directions
        assign mac_clk_en_o[p] = pll_clk_en_o & pif.clk_en & ~low_power[p] & ~port_pd[p];
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    one_wait_a: assert property (req && avs_waitrequest_o && $stable(avs_address_i) |=> !avs_waitrequest_o)
        else $error("access not answered after one wait state");
    mode_decode_a: assert property (wr_lane0 && hit_mode && !is_soft && wr_enc == spm_pkg::ENC_ENERGY
                                    |=> mode_q == spm_pkg::MODE_ENERGY)
        else $error("energy code did not select energy mode");
    rsvd_keep_a: assert property (wr_lane0 && hit_mode && wr_enc == spm_pkg::ENC_RSVD && !is_soft
                                  |=> mode_q == $past(mode_q))
        else $error("reserved code changed the mode");
    soft_off_a: assert property (is_soft |-> !pll_clk_en_o && phy_enable_o == '0 && mac_clk_en_o == '0)
        else $error("clocks or PHY alive in soft power-down");
    wake_reset_a: assert property (wake_access |=> mode_q == spm_pkg::MODE_NORMAL
                                   && sleep_delay == spm_pkg::SLEEP_DELAY_RST && soft_reset_o)
        else $error("host access did not wake and reset");
    port_off_a: assert property ((port_pd | phy_basic_control_pd_i) != '0
                                 |-> (phy_enable_o & (port_pd | phy_basic_control_pd_i)) == '0)
        else $error("powered-down port PHY still enabled");
    sleep_gate_a: assert property (all_asleep |-> !pll_clk_en_o && !host_if_en_o && phy_enable_o == '0)
        else $error("circuitry alive in low-power state");
    normal_run_a: assert property (mode_q == spm_pkg::MODE_NORMAL |-> pll_clk_en_o && host_if_en_o)
        else $error("normal mode lost clocks");
endmodule

// ---- dv/spm_phy_model.sv ----
// Behavioural line side: cable energy and receive MII codes for each port.
module spm_phy_model (
    input wire logic sys_clk_i,
    input wire logic [2:0] cable_i,
    input wire logic [2:0] idle_i,
    output logic [2:0] energy_o,
    output logic [2:0] rx_lpi_o,
    output logic [2:0] rx_ifg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Codes follow the partner one cycle late, like a real receive path
    always @(posedge sys_clk_i) begin
        energy_o <= cable_i;
        rx_lpi_o <= idle_i;
        rx_ifg_o <= ~idle_i; // Normal gap code whenever not idle
    end
endmodule

// ---- dv/spm_power_ctrl_test.sv ----
// Self-checking bench for the power-mode controller with a register model.
module spm_power_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SEC = 200; // Short second keeps the run brief
    localparam int UNIT = 20; // Short sleep unit
    logic clk = 0, rst = 1, rd = 0, wr = 0, wait_o, pll, hif, srst;
    logic [8:0] adr = '0;
    logic [31:0] wd = '0, rdat, q, rnd = 32'hA2EF;
    logic [3:0] be = 4'hF;
    logic [2:0] cab = 3'h7, idl = '0, pd = '0, ladv = '0, padv = '0, busy = '0;
    logic [2:0] en, lpi, ifg, phy, pul, txl, crs, flg, mce;
    int error_cnt = 0, comparisons = 0, n;
    logic [7:0] m [int]; // Register model keyed by byte address
    bit spd = 0; // Model sits in soft power-down
    spm_power_ctrl #(.SEC_CYC(SEC), .SLEEP_UNIT_CYC(UNIT)) uut (
        .sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .energy_i(en), .phy_basic_control_pd_i(pd), .eee_local_adv_i(ladv), .eee_partner_adv_i(padv),
        .mac_tx_busy_i(busy), .mii_rx_lpi_i(lpi), .mii_rx_ifg_i(ifg), .phy_enable_o(phy),
        .link_pulse_o(pul), .mii_tx_lpi_o(txl), .mac_crs_hold_o(crs), .partner_idle_flag_o(flg),
        .mac_clk_en_o(mce), .pll_clk_en_o(pll), .host_if_en_o(hif), .soft_reset_o(srst));
    spm_phy_model phy_m (.sys_clk_i(clk), .cable_i(cab), .idle_i(idl), .energy_o(en), .rx_lpi_o(lpi),
        .rx_ifg_o(ifg));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic mreset();
        m = '{'h38: 8'h00, 'h3C: 8'h50, 'h74: 8'h00, 'hB4: 8'h00, 'hF4: 8'h00};
    endtask
    // One Avalon access; the model answers reads and mirrors writes
    task automatic bus(input bit w, input int a, input logic [7:0] d);
        int k;
        logic [7:0] e;
        rnd = xs(rnd);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a[8:0];
        wd <= {rnd[31:8], d}; // Upper lanes are noise the slave must ignore
        be <= {rnd[3:1], 1'b1};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wait_o !== 1'b0 && k < 50);
        q = rdat;
        rd <= 0;
        wr <= 0;
        e = m.exists(a) ? m[a] : 8'h00;
        if (!w) chk("readdata", q, {24'h0, e});
        if (spd) begin
            spd = 0; // Wake access is answered, then every register resets
            mreset();
        end else if (w && m.exists(a) && !(a == 'h38 && d[4:3] == 2'h3)) begin
            m[a] = d & (a == 'h3C ? 8'hFF : a == 'h38 ? 8'h18 : 8'h08);
            spd = (a == 'h38 && d[4:3] == 2'h2);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #(20000 * 10);
        error_cnt++;
        end_of_test();
    end
    initial begin
        mreset();
        repeat (6) @(posedge clk);
        rst <= 0;
        bus(0, 'h38, 0);
        bus(0, 'h3C, 0);
        bus(1, 'h004, 8'h5A); // Unmapped place keeps nothing
        bus(0, 'h004, 0);
        bus(1, 'h38, 8'h18); // Reserved code leaves the mode alone
        bus(0, 'h38, 0);
        // Port PHY off by its control bit or by the PHY's own bit
        for (int i = 0; i < 6; i++) begin
            pd <= rnd[10:8];
            bus(1, 'h74 + 'h40 * (i % 3), rnd[7:0]);
            bus(0, 'h74 + 'h40 * (i % 3), 0);
            chk("phy_enable", phy, 3'(~(pd | {m['hF4][3], m['hB4][3], m['h74][3]})));
        end
        pd <= 3'h0;
        for (int p = 0; p < 3; p++) bus(1, 'h74 + 'h40 * p, 0);
        // Idle request: busy MAC and one-sided capability both hold it back
        ladv <= 3'h7;
        padv <= 3'h5;
        busy <= 3'h1;
        bus(1, 'h1C0, 8'h03);
        repeat (4) @(posedge clk);
        chk("tx_lpi", txl, 3'h0);
        busy <= 3'h0;
        repeat (4) @(posedge clk);
        chk("tx_lpi", txl, 3'h1);
        chk("crs_hold", crs[0], 1'b1);
        idl <= 3'h1;
        repeat (6) @(posedge clk);
        chk("idle_flag", flg, 3'h1);
        chk("mac_clk_en", mce, 3'h6);
        idl <= 3'h0;
        bus(1, 'h1C0, 8'h00);
        repeat (6) @(posedge clk);
        chk("flag_and_tx_lpi", {flg, txl}, 6'h0);
        chk("crs_hold", crs[0], 1'b1); // MAC still held after idle ends
        repeat (spm_pkg::WAKE_CYC) @(posedge clk);
        chk("crs_hold", crs, 3'h0);
        // Energy mode: sleep after delay+1 quiet units, pulse, then wake
        bus(1, 'h3C, 8'h02);
        bus(1, 'h38, 8'h08);
        cab <= 3'h0;
        repeat (30) @(posedge clk);
        chk("pll_clk_en", pll, 1'b1);
        repeat (90) @(posedge clk);
        chk("pll_host_en", {pll, hif}, 2'h0);
        // Align the window to a pulse start so the free-running second cannot split a pulse
        for (int i = 0; i < SEC && pul[0] !== 1'b0; i++) @(posedge clk);
        for (int i = 0; i < SEC && pul[0] !== 1'b1; i++) @(posedge clk);
        n = 0;
        repeat (SEC) begin
            @(posedge clk);
            n += (pul[0] === 1'b1);
        end
        chk("pulse_cycles", n, spm_pkg::PULSE_CYC);
        cab <= 3'h7;
        repeat (4) @(posedge clk);
        chk("pll_clk_en", pll, 1'b1);
        bus(1, 'h38, 8'h00);
        bus(1, 'h38, 8'h10); // Soft power-down from normal mode
        @(posedge clk);
        chk("clocks_and_phy", {pll, mce, phy}, 7'h0);
        bus(0, 'h38, 0);
        @(negedge clk); // Internal reset pulse stands in the cycle after the wake access
        chk("soft_reset", srst, 1'b1);
        bus(0, 'h3C, 0);
        chk("pll_clk_en", pll, 1'b1);
        end_of_test();
    end
endmodule
